// ===== hbr_regs.svh
// ************************************************************
// Register codes, field positions, reset values and timing.
// ************************************************************
`ifndef HBR_REGS_SVH
`define HBR_REGS_SVH

// Address byte layout: direction bit, register code field, marker bits.
`define HBR_DIR_BIT 7
`define HBR_CODE_HI 6
`define HBR_CODE_LO 2
`define HBR_DIR_WRITE 1'h1
`define HBR_DIR_READ 1'h0

// Register codes carried in the code field of the address byte.
`define HBR_CODE_OE_A 5'h00
`define HBR_CODE_OE_B 5'h01
`define HBR_CODE_OC_C 5'h0F
`define HBR_CODE_OL_A 5'h10
`define HBR_CODE_OL_B 5'h11
`define HBR_CODE_OL_C 5'h12

// Reset values of the byte-wide registers.
`define HBR_CTRL_RESET 8'h00
`define HBR_FLAG_RESET 8'h00

// Frame length, address byte length and bit counter ceiling.
`define HBR_FRAME_BITS 5'h10
`define HBR_ADDR_BITS 5'h08
`define HBR_CNT_MAX 5'h1F

// Serial clock half period and the clock it is derived from.
`define HBR_CLK_PERIOD_NS 10
`define HBR_SCLK_HALF_NS 500
`define HBR_SCLK_HALF_CYC ((`HBR_SCLK_HALF_NS + `HBR_CLK_PERIOD_NS - 1) / `HBR_CLK_PERIOD_NS)

// Controller register offsets on its software port.
`define HBR_HOST_CMD 4'h0
`define HBR_HOST_RX 4'h1
`define HBR_HOST_STAT 4'h2
`define HBR_HOST_MASK 4'h3

// Controller status bit positions.
`define HBR_STAT_DONE 0
`define HBR_STAT_REFUSED 1
`define HBR_STAT_BUSY 8

`endif

// ===== hbr_pkg.sv
// ************************************************************
// Types shared by both ends of the serial link.
// ************************************************************
package hbr_pkg;

	// Sequencer states of the controller.
	typedef enum logic [2:0] {hs_idle, hs_lead, hs_high, hs_low, hs_tail, hs_gap} hbr_host_state_e;

	// Complete state of the driver end.
	typedef struct packed {
		logic sclk_q;
		logic cs_q;
		logic [4:0] cnt;
		logic [15:0] rx;
		logic [7:0] tx;
		logic [7:0] rep;
		logic [7:0] oe_a;
		logic [7:0] oe_b;
		logic [7:0] oc_c;
		logic [7:0] ol_a;
		logic [7:0] ol_b;
		logic [7:0] ol_c;
		logic [7:0] high_on;
		logic [7:0] low_on;
	} hbr_dev_s;

	// Complete state of the controller end.
	typedef struct packed {
		hbr_host_state_e state;
		logic [15:0] div;
		logic [4:0] bits;
		logic [15:0] shift_out;
		logic [15:0] shift_in;
		logic [15:0] rx;
		logic sclk;
		logic cs_n;
		logic mosi;
		logic done;
		logic refused;
		logic [1:0] mask;
		logic [15:0] rdata;
	} hbr_host_s;

endpackage

// ===== hbr_spi_if.sv
`timescale 1ns/1ps
// ************************************************************
// Serial link between controller and driver.
// ************************************************************
interface hbr_spi_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;

	// Controller drives clock, select and command data.
	modport host (output sclk, output cs_n, output mosi, input miso);

	// Driver returns the addressed register on its own line.
	modport dev (input sclk, input cs_n, input mosi, output miso);
endinterface

// ===== hbr_device.sv
`timescale 1ns/1ps
`include "hbr_regs.svh"

module hbr_device
(
	input wire logic clk_sys,
	input wire logic rst_n,
	hbr_spi_if.dev spi,
	input wire logic [7:0] overcurrent_fault,
	input wire logic [23:0] open_load_fault,
	output logic [7:0] high_on,
	output logic [7:0] low_on
);

	// ************************************************************
	// State and decoded frame fields.
	// ************************************************************
	hbr_pkg::hbr_dev_s r;
	hbr_pkg::hbr_dev_s next_r;
	logic sclk_rise;
	logic sclk_fall;
	logic frame_end;
	logic frame_whole;
	logic [7:0] addr_byte;
	logic [7:0] data_byte;
	logic [4:0] live_code;
	logic [4:0] done_code;
	logic done_dir;
	logic [7:0] read_value;
	logic [7:0] clr_oc_c;
	logic [7:0] clr_ol_a;
	logic [7:0] clr_ol_b;
	logic [7:0] clr_ol_c;

	// ************************************************************
	// Link edge detection.
	// ************************************************************

	// Edges are found against the copy taken one cycle earlier.
	assign sclk_rise = spi.sclk & ~r.sclk_q;
	assign sclk_fall = ~spi.sclk & r.sclk_q;

	// A frame ends when select rises; it counts only at exactly sixteen bits.
	assign frame_end = spi.cs_n & ~r.cs_q;
	assign frame_whole = frame_end & (r.cnt == `HBR_FRAME_BITS);

	// The received word splits into address byte and data byte.
	assign addr_byte = r.rx[15:8];
	assign data_byte = r.rx[7:0];
	assign done_code = addr_byte[`HBR_CODE_HI:`HBR_CODE_LO];
	assign done_dir = addr_byte[`HBR_DIR_BIT];

	// Before the data byte starts shifting, the low byte holds the address.
	assign live_code = r.rx[`HBR_CODE_HI:`HBR_CODE_LO];

	// ************************************************************
	// Read multiplexer.
	// ************************************************************

	// Unmapped codes read as zero.
	always_comb
	begin
		case (live_code)
			`HBR_CODE_OE_A: read_value = r.oe_a;
			`HBR_CODE_OE_B: read_value = r.oe_b;
			`HBR_CODE_OC_C: read_value = r.oc_c;
			`HBR_CODE_OL_A: read_value = r.ol_a;
			`HBR_CODE_OL_B: read_value = r.ol_b;
			`HBR_CODE_OL_C: read_value = r.ol_c;
			default: read_value = 8'h00;
		endcase
	end

	// ************************************************************
	// Clear masks for flags that a completed read reported.
	// ************************************************************

	// Only bits that were shifted out are cleared, so later faults survive.
	always_comb
	begin
		clr_oc_c = 8'h00;
		clr_ol_a = 8'h00;
		clr_ol_b = 8'h00;
		clr_ol_c = 8'h00;
		if (frame_whole && (done_dir == `HBR_DIR_READ))
		begin
			case (done_code)
				`HBR_CODE_OC_C: clr_oc_c = r.rep;
				`HBR_CODE_OL_A: clr_ol_a = r.rep;
				`HBR_CODE_OL_B: clr_ol_b = r.rep;
				`HBR_CODE_OL_C: clr_ol_c = r.rep;
				default: clr_oc_c = 8'h00;
			endcase
		end
	end

	// ************************************************************
	// Next state.
	// ************************************************************

	// Shifting, register update, flag capture and switch drive.
	always_comb
	begin
		next_r = r;
		next_r.sclk_q = spi.sclk;
		next_r.cs_q = spi.cs_n;

		// Shift engine, held idle while select is high.
		if (spi.cs_n)
		begin
			next_r.cnt = 5'h00;
			next_r.tx = 8'h00;
		end
		else
		begin
			if (sclk_rise)
			begin
				next_r.rx = {r.rx[14:0], spi.mosi};
				if (r.cnt != `HBR_CNT_MAX)
				begin
					next_r.cnt = r.cnt + 5'h01;
				end
			end
			if (sclk_fall)
			begin
				if (r.cnt == `HBR_ADDR_BITS)
				begin
					next_r.tx = read_value;
					next_r.rep = read_value;
				end
				else
				begin
					next_r.tx = {r.tx[6:0], 1'b0};
				end
			end
		end

		// Control registers change only on a whole write frame.
		if (frame_whole && (done_dir == `HBR_DIR_WRITE))
		begin
			case (done_code)
				`HBR_CODE_OE_A: next_r.oe_a = data_byte;
				`HBR_CODE_OE_B: next_r.oe_b = data_byte;
				default: next_r.oe_a = r.oe_a;
			endcase
		end

		// A read frame leaves control registers as they are.

		// Flags: a fault in the clearing cycle wins over the clear.
		next_r.oc_c = (r.oc_c & ~clr_oc_c) | overcurrent_fault;
		next_r.ol_a = (r.ol_a & ~clr_ol_a) | open_load_fault[7:0];
		next_r.ol_b = (r.ol_b & ~clr_ol_b) | open_load_fault[15:8];
		next_r.ol_c = (r.ol_c & ~clr_ol_c) | open_load_fault[23:16];

		// Bridges 1 to 4 from register A, 5 to 8 from register B.
		for (int n = 0; n < 4; n++)
		begin
			next_r.low_on[n] = r.oe_a[2 * n] & ~r.oe_a[2 * n + 1];
			next_r.high_on[n] = r.oe_a[2 * n + 1] & ~r.oe_a[2 * n];
			next_r.low_on[n + 4] = r.oe_b[2 * n] & ~r.oe_b[2 * n + 1];
			next_r.high_on[n + 4] = r.oe_b[2 * n + 1] & ~r.oe_b[2 * n];
		end
	end

	// ************************************************************
	// State register.
	// ************************************************************

	// Synchronous reset puts every register and switch at zero, except the select copy, which is set high.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.cs_q <= 1'b1;
			r.oe_a <= `HBR_CTRL_RESET;
			r.oe_b <= `HBR_CTRL_RESET;
			r.oc_c <= `HBR_FLAG_RESET;
			r.ol_a <= `HBR_FLAG_RESET;
			r.ol_b <= `HBR_FLAG_RESET;
			r.ol_c <= `HBR_FLAG_RESET;
		end
		else
		begin
			r <= next_r;
		end
	end

	// ************************************************************
	// Outputs.
	// ************************************************************

	// All outputs come straight from flip-flops.
	assign spi.miso = r.tx[7];
	assign high_on = r.high_on;
	assign low_on = r.low_on;

endmodule

// ===== hbr_host.sv
`timescale 1ns/1ps
`include "hbr_regs.svh"

module hbr_host
#(
	parameter int unsigned HALF_CYCLES = `HBR_SCLK_HALF_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic irq,
	hbr_spi_if.host spi
);

	// ************************************************************
	// State.
	// ************************************************************
	hbr_pkg::hbr_host_s r;
	hbr_pkg::hbr_host_s next_r;
	logic half_done;
	logic busy;
	logic cmd_wr;
	logic [15:0] stat_word;

	// Half period reached, sequencer busy, command write decoded.
	assign half_done = (r.div == 16'(HALF_CYCLES - 1));
	assign busy = (r.state != hbr_pkg::hs_idle);
	assign cmd_wr = wr && (addr == `HBR_HOST_CMD);

	// Status word: sticky events and the busy level.
	always_comb
	begin
		stat_word = 16'h0000;
		stat_word[`HBR_STAT_DONE] = r.done;
		stat_word[`HBR_STAT_REFUSED] = r.refused;
		stat_word[`HBR_STAT_BUSY] = busy;
	end

	// ************************************************************
	// Sequencer and software registers.
	// ************************************************************

	// Frame is sent most significant bit first, sampled on rising clock.
	always_comb
	begin
		next_r = r;
		next_r.div = half_done ? 16'h0000 : r.div + 16'h0001;
		case (r.state)
			hbr_pkg::hs_idle:
			begin
				next_r.div = 16'h0000;
				if (cmd_wr)
				begin
					next_r.shift_out = wdata;
					next_r.mosi = wdata[15];
					next_r.cs_n = 1'b0;
					next_r.bits = 5'h00;
					next_r.state = hbr_pkg::hs_lead;
				end
			end
			hbr_pkg::hs_lead, hbr_pkg::hs_low:
			begin
				if (half_done)
				begin
					next_r.sclk = 1'b1;
					next_r.shift_in = {r.shift_in[14:0], spi.miso};
					next_r.state = hbr_pkg::hs_high;
				end
			end
			hbr_pkg::hs_high:
			begin
				if (half_done)
				begin
					next_r.sclk = 1'b0;
					next_r.bits = r.bits + 5'h01;
					next_r.shift_out = {r.shift_out[14:0], 1'b0};
					next_r.mosi = r.shift_out[14];
					next_r.state = (r.bits == 5'h0F) ? hbr_pkg::hs_tail : hbr_pkg::hs_low;
				end
			end
			hbr_pkg::hs_tail:
			begin
				if (half_done)
				begin
					next_r.cs_n = 1'b1;
					next_r.mosi = 1'b0;
					next_r.rx = r.shift_in;
					next_r.state = hbr_pkg::hs_gap;
				end
			end
			hbr_pkg::hs_gap:
			begin
				if (half_done)
				begin
					next_r.state = hbr_pkg::hs_idle;
				end
			end
			default: next_r.state = hbr_pkg::hs_idle;
		endcase

		// Sticky events, write one to clear, the setting event wins.
		if (wr && (addr == `HBR_HOST_STAT))
		begin
			next_r.done = r.done & ~wdata[`HBR_STAT_DONE];
			next_r.refused = r.refused & ~wdata[`HBR_STAT_REFUSED];
		end
		if ((r.state == hbr_pkg::hs_tail) && half_done)
		begin
			next_r.done = 1'b1;
		end
		if (cmd_wr && busy)
		begin
			next_r.refused = 1'b1;
		end
		if (wr && (addr == `HBR_HOST_MASK))
		begin
			next_r.mask = wdata[1:0];
		end

		// Read data stands in the cycle after the strobe.
		next_r.rdata = 16'h0000;
		if (rd)
		begin
			case (addr)
				`HBR_HOST_RX: next_r.rdata = r.rx;
				`HBR_HOST_STAT: next_r.rdata = stat_word;
				`HBR_HOST_MASK: next_r.rdata = {14'h0000, r.mask};
				default: next_r.rdata = 16'h0000;
			endcase
		end
	end

	// Synchronous reset leaves select high and the clock low.
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			r <= '0;
			r.cs_n <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	// Link pins and interrupt.
	assign spi.sclk = r.sclk;
	assign spi.cs_n = r.cs_n;
	assign spi.mosi = r.mosi;
	assign rdata = r.rdata;
	assign irq = |({r.refused, r.done} & r.mask);

endmodule

// ===== hbr_link_monitor.sv
`timescale 1ns/1ps
// ************************************************************
// Serial link checks between controller and driver.
// ************************************************************
module hbr_link_monitor
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso
);
	logic sclk_d;
	logic [4:0] rises;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// Counts serial clock rises inside one frame.
	always_ff @(posedge clk_sys)
	begin
		sclk_d <= sclk;
		if (!rst_n || cs_n)
			rises <= 5'h00;
		else if (sclk && !sclk_d)
			rises <= rises + 5'h01;
	end

	// Clock phases last two system cycles in simulation.
	sequence s_high;
		sclk [*2] ##1 !sclk;
	endsequence
	sequence s_low;
		!sclk [*2];
	endsequence

	a_frame_sixteen: assert property ($rose(cs_n) |-> rises == 5'h10)
		else $error("frame did not carry sixteen clocks");
	a_addr_slot_zero: assert property ($rose(sclk) && rises < 5'h08 |-> !miso)
		else $error("reply line busy during address byte");
	a_idle_reply: assert property (cs_n && $past(cs_n) |-> !miso)
		else $error("reply line high while deselected");
	a_sclk_high: assert property ($rose(sclk) |-> s_high)
		else $error("serial clock high phase wrong");
	a_sclk_low: assert property ($fell(sclk) |-> s_low)
		else $error("serial clock low phase wrong");
	a_select_lead: assert property ($fell(cs_n) |-> s_low ##1 sclk)
		else $error("first clock not two cycles after select");
	a_clock_selected: assert property (sclk |-> !cs_n)
		else $error("serial clock high while deselected");
	a_command_steady: assert property (sclk |-> $stable(mosi))
		else $error("command line moved while clock high");
	a_gap_after: assert property ($rose(cs_n) |=> cs_n)
		else $error("frames not separated");
endmodule

// ===== half_bridge_spi_register_bank_tb_top.sv
`timescale 1ns/1ps
`include "hbr_regs.svh"
// ************************************************************
// Bench joining controller and driver across the link.
// ************************************************************
module half_bridge_spi_register_bank_tb_top;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic irq;
	logic [7:0] overcurrent_fault = 8'h00;
	logic [23:0] open_load_fault = 24'h00_0000;
	logic [7:0] high_on;
	logic [7:0] low_on;
	logic [1:0] mask_m = 2'h0;
	logic ref_exp = 1'b0;
	logic [7:0] mdl [6] = '{default: 8'h00};
	logic [4:0] codes [6] = '{`HBR_CODE_OE_A, `HBR_CODE_OE_B, `HBR_CODE_OC_C,
		`HBR_CODE_OL_A, `HBR_CODE_OL_B, `HBR_CODE_OL_C};
	logic [15:0] rx;
	logic [15:0] s;
	logic [31:0] f;
	logic [7:0] d;
	int n_errors = 0;
	int num_checks = 0;

	hbr_spi_if link();
	hbr_device hbr_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .spi(link),
		.overcurrent_fault(overcurrent_fault), .open_load_fault(open_load_fault),
		.high_on(high_on), .low_on(low_on));
	hbr_host #(.HALF_CYCLES(2)) hbr_host_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .spi(link));
	hbr_link_monitor hbr_link_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

	// System clock at 100 MHz.
	initial
	begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic sw_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	task automatic sw_rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	// Sends one frame, waits for idle, checks and clears status.
	task automatic frame(input logic [7:0] a, input logic [7:0] v, output logic [15:0] r);
		logic [15:0] st;
		sw_wr(`HBR_HOST_CMD, {a, v});
		for (int i = 0; i < 300; i++)
		begin
			sw_rd(`HBR_HOST_STAT, st);
			if (st[`HBR_STAT_BUSY] === 1'b0)
				break;
		end
		check("status", 16'(st[1:0]), 16'({ref_exp, 1'b1}));
		check("irq", 16'(irq), 16'(|({ref_exp, 1'b1} & mask_m)));
		sw_wr(`HBR_HOST_STAT, 16'h0003);
		sw_rd(`HBR_HOST_RX, r);
		check("irq cleared", 16'(irq), 16'h0000);
	endtask

	function automatic logic [7:0] ab(input int dir, input int k);
		return {dir[0], codes[k], 2'h0};
	endfunction

	// Expected {high, low} switch states with cross-current lockout.
	function automatic logic [15:0] sw_exp();
		logic [15:0] v;
		logic [15:0] r;
		v = {mdl[1], mdl[0]};
		for (int k = 0; k < 8; k++)
		begin
			r[k + 8] = v[2 * k + 1] & !v[2 * k];
			r[k] = v[2 * k] & !v[2 * k + 1];
		end
		return r;
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence of tests.
	initial
	begin
		void'($urandom(32'h6b37_2b18));
		repeat (12) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			frame(ab(0, k), 8'h00, rx);
			check("reset value", rx, 16'h0000);
		end
		check("switches reset", {high_on, low_on}, 16'h0000);
		$display("reset test done");
		for (int t = 0; t < 8; t++)
		begin
			d = (t < 2) ? 8'hFF : 8'($urandom);
			mask_m = 2'(t / 2);
			sw_wr(`HBR_HOST_MASK, 16'(mask_m));
			sw_rd(`HBR_HOST_MASK, s);
			check("mask", s, 16'(mask_m));
			frame(ab(1, t % 2), d, rx);
			mdl[t % 2] = d;
			frame(ab(0, t % 2), 8'($urandom), rx);
			check("enable", rx, {8'h00, mdl[t % 2]});
			check("switches", {high_on, low_on}, sw_exp());
		end
		$display("enable test done");
		for (int t = 0; t < 3; t++)
		begin
			f = $urandom;
			@(posedge clk_sys);
			overcurrent_fault <= f[7:0];
			open_load_fault <= f[31:8];
			@(posedge clk_sys);
			overcurrent_fault <= 8'h00;
			open_load_fault <= 24'h00_0000;
			{mdl[5], mdl[4], mdl[3], mdl[2]} = f;
			for (int k = 2; k < 6; k++)
			begin
				frame(ab(1, k), 8'hFF, rx);
				frame(ab(0, k), 8'h00, rx);
				check("flags", rx, {8'h00, mdl[k]});
				frame(ab(0, k), 8'h00, rx);
				check("flags cleared", rx, 16'h0000);
			end
		end
		check("switches kept", {high_on, low_on}, sw_exp());
		$display("flag test done");
		mask_m = 2'h2;
		sw_wr(`HBR_HOST_MASK, 16'h0002);
		sw_wr(`HBR_HOST_CMD, {ab(0, 0), 8'h00});
		ref_exp = 1'b1;
		frame(ab(0, 0), 8'h00, rx);
		ref_exp = 1'b0;
		check("refused frame", rx, {8'h00, mdl[0]});
		sw_rd(4'h7, s);
		check("unmapped", s, 16'h0000);
		$display("controller test done");
		// A reset in mid-run must return both enable registers to zero.
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		mask_m = 2'h0;
		mdl[0] = 8'h00;
		mdl[1] = 8'h00;
		for (int k = 0; k < 2; k++)
		begin
			frame(ab(0, k), 8'h00, rx);
			check("enable after reset", rx, {8'h00, mdl[k]});
		end
		check("switches after reset", {high_on, low_on}, sw_exp());
		$display("second reset test done");
		conclude();
	end

	// Cuts a hung run short.
	initial
	begin
		#400000;
		n_errors++;
		conclude();
	end
endmodule
